// ### verification/host_model.sv
// Host model that drives the enable pin and the register strobe port.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic       clk,
  // Enable pin
  output var  logic       en_pin,
  // Register port
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  initial begin
    en_pin    = 1'b0;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // Reserved bits go out as zero unless a refusal is provoked with raw.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic raw);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= (a == 8'h12 && !raw) ? (d & 8'h77) : d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    // Stale data is inverted so a design that ignores the strobe is caught.
    reg_wdata <= ~reg_wdata;
  endtask

  // The read word is taken one edge late; it holds until the next read.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata_q;
  endtask

  task automatic set_en(input logic v);
    @(posedge clk);
    en_pin <= v;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the rail and output sequencing block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk;
  logic       rst_n;
  logic       en_pin;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic       linear_reg_b_en_q;
  logic       aux_a_out_q;
  logic       aux_a_oe_n_q;
  logic       aux_b_out_q;
  logic       aux_b_oe_n_q;
  logic [4:0] cfg_outs;
  logic [7:0] rd_val;
  int         failures;
  int         num_checks;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  host_model host (
    .clk         (clk),
    .en_pin      (en_pin),
    .reg_addr    (reg_addr),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_wdata   (reg_wdata),
    .reg_rdata_q (reg_rdata_q)
  );

  // A half step of four cycles keeps the longest delay near 120 cycles.
  rail_and_output_sequencing #(
    .HALF_STEP_CYCLES (4)
  ) dut (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .en_pin                (en_pin),
    .reg_addr              (reg_addr),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_wdata             (reg_wdata),
    .reg_rdata_q           (reg_rdata_q),
    .linear_reg_b_en_q     (linear_reg_b_en_q),
    .aux_a_out_q           (aux_a_out_q),
    .aux_a_oe_n_q          (aux_a_oe_n_q),
    .aux_b_out_q           (aux_b_out_q),
    .aux_b_oe_n_q          (aux_b_oe_n_q),
    .ext_clock_sel_q(cfg_outs[4]),
    .shared_pin_pulldown_q(cfg_outs[3]),
    .enable_pin_pulldown_q(cfg_outs[2]),
    .thermal_warn_high_q(cfg_outs[1]),
    .spread_spectrum_on_q(cfg_outs[0])
  );

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // A released open-drain pin is read as pulled high.
  function automatic logic pin(input logic oe_n, input logic out);
    return oe_n ? 1'b1 : out;
  endfunction

  function automatic logic [1:0] exp_pin(input logic [2:0] f, input logic s);
    logic lvl;
    lvl = f[0] & (!f[1] | s);
    return f[2] ? {1'b0, lvl} : {lvl, 1'b0};
  endfunction

  // Counts edges from the enable change to the first new level per output.
  task automatic measure(input logic v, input int t0, input int t1,
                         input int t2);
    int         first[3];
    logic [2:0] now;
    first = '{-1, -1, -1};
    for (int i = 1; i <= 160; i++) begin
      @(posedge clk);
      #1;
      now = {pin(aux_b_oe_n_q, aux_b_out_q), pin(aux_a_oe_n_q, aux_a_out_q),
             linear_reg_b_en_q};
      for (int c = 0; c < 3; c++) begin
        if (now[c] === v && first[c] < 0) begin
          first[c] = i;
        end
      end
    end
    cmp(8'(first[0]), 8'(t0));
    cmp(8'(first[1]), 8'(t1));
    cmp(8'(first[2]), 8'(t2));
  endtask

  task automatic t_reset;
    logic [7:0] exp[6];
    exp = '{8'h26, 8'h0A, 8'h32, 8'h77, 8'h06, 8'h00};
    for (int i = 0; i < 6; i++) begin
      host.rd(8'(8'h0F + i), rd_val);
      cmp(rd_val, exp[i]);
    end
    cmp(8'(cfg_outs), 8'h06);
  endtask

  task automatic t_default_timing;
    host.set_en(1'b1);
    measure(1'b1, 27, 43, 11);
    host.set_en(1'b0);
    measure(1'b0, 11, 2, 15);
  endtask

  task automatic t_long_range;
    host.wr(8'h13, 8'h66, 1'b0);
    host.wr(8'h10, 8'hF1, 1'b0);
    host.set_en(1'b1);
    measure(1'b1, 51, 11, 19);
    host.set_en(1'b0);
    measure(1'b0, 19, 123, 27);
    host.wr(8'h13, 8'h06, 1'b0);
    host.wr(8'h10, 8'h0A, 1'b0);
  endtask

  // Zero codes switch regulator B two edges after the pin moves.
  task automatic t_zero_delay;
    host.wr(8'h0F, 8'h00, 1'b0);
    host.set_en(1'b1);
    measure(1'b1, 2, 43, 11);
    host.set_en(1'b0);
    measure(1'b0, 2, 2, 15);
    host.wr(8'h0F, 8'h26, 1'b0);
  endtask

  // Pulses shorter than every pending delay must leave no trace.
  task automatic t_restart;
    host.set_en(1'b1);
    repeat (6) @(posedge clk);
    host.set_en(1'b0);
    repeat (6) @(posedge clk);
    host.set_en(1'b1);
    measure(1'b1, 27, 43, 11);
  endtask

  task automatic t_pin_modes;
    logic [1:0] e;
    for (int s = 1; s >= 0; s--) begin
      for (int k = 0; k < 8; k++) begin
        host.wr(8'h12, {1'b0, 3'(k), 1'b0, 3'(k)}, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        e = exp_pin(3'(k), 1'(s));
        cmp(8'({aux_a_out_q, aux_a_oe_n_q}), 8'(e));
        cmp(8'({aux_b_out_q, aux_b_oe_n_q}), 8'(e));
      end
      host.set_en(1'b0);
      repeat (130) @(posedge clk);
    end
    host.wr(8'h12, 8'hFF, 1'b1);
    host.rd(8'h12, rd_val);
    cmp(rd_val, 8'h77);
  endtask

  task automatic t_config;
    logic [7:0] v[4];
    v = '{8'h1F, 8'h00, 8'h15, 8'h0A};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h13, v[i], 1'b0);
      repeat (2) @(posedge clk);
      #1;
      cmp(8'(cfg_outs), 8'(v[i][4:0]));
      cmp(8'(aux_b_oe_n_q), 8'(v[i][4]));
      host.rd(8'h13, rd_val);
      cmp(rd_val, v[i]);
    end
    host.wr(8'h13, 8'h06, 1'b0);
  endtask

  task automatic end_of_test;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    failures   = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_default_timing();
    t_long_range();
    t_zero_delay();
    t_restart();
    t_pin_modes();
    t_config();
    end_of_test();
  end

  // The scenarios need about 1500 cycles; a hang stops well past that.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ### verilog/delay_channel.sv
// One delayed on/off channel driven by enable edges and half-step ticks.
`timescale 1ns/10ps
`default_nettype none
module delay_channel #(
  parameter int CODE_W = 4,
  parameter int CNT_W  = 5
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Enable edges and time base
  input  wire logic              rise,
  input  wire logic              fall,
  input  wire logic              tick,
  // Delay settings
  input  wire logic [CODE_W-1:0] on_code,
  input  wire logic [CODE_W-1:0] off_code,
  input  wire logic              on_long,
  input  wire logic              off_long,
  // Sequenced level
  output wire logic              active
);
  seq_pkg::seq_state_e state_q;
  logic [CNT_W-1:0]    cnt_q;

  function automatic logic [CNT_W-1:0] steps(input logic [CODE_W-1:0] c,
                                             input logic lng);
    steps = lng ? CNT_W'({c, 1'b0}) : CNT_W'(c);
  endfunction

  // A new edge always reloads, so only the latest edge counts.
  // An edge that cancels a pending change leaves the level as it stands,
  // so a short enable pulse never makes a stray output pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= seq_pkg::SEQ_OFF;
      cnt_q   <= '0;
    end else if (rise) begin
      if (state_q[1] || on_code == '0) begin
        state_q <= seq_pkg::SEQ_ON;
      end else begin
        state_q <= seq_pkg::SEQ_WAIT_ON;
      end
      cnt_q   <= steps(on_code, on_long);
    end else if (fall) begin
      if (!state_q[1] || off_code == '0) begin
        state_q <= seq_pkg::SEQ_OFF;
      end else begin
        state_q <= seq_pkg::SEQ_WAIT_OFF;
      end
      cnt_q   <= steps(off_code, off_long);
    end else if (tick) begin
      case (state_q)
        seq_pkg::SEQ_WAIT_ON: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= seq_pkg::SEQ_ON;
          end
          cnt_q <= cnt_q - CNT_W'(1);
        end
        seq_pkg::SEQ_WAIT_OFF: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= seq_pkg::SEQ_OFF;
          end
          cnt_q <= cnt_q - CNT_W'(1);
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // Gray coding puts the output level in the upper state bit.
  assign active = state_q[1];

  property p_on_load;
    @(posedge clk) disable iff (!rst_n)
    rise |=> cnt_q == ($past(on_long) ? CNT_W'({$past(on_code), 1'b0})
                                      : CNT_W'($past(on_code)));
  endproperty
  a_on_load: assert property (p_on_load)
    else $error("startup count not loaded from code and range");

  property p_off_load;
    @(posedge clk) disable iff (!rst_n)
    (fall && !rise && off_long) |=> cnt_q == CNT_W'({$past(off_code), 1'b0});
  endproperty
  a_off_load: assert property (p_off_load)
    else $error("shutdown count not doubled in long range");

  property p_expire;
    @(posedge clk) disable iff (!rst_n)
    (tick && !rise && !fall && cnt_q == CNT_W'(1)
     && state_q == seq_pkg::SEQ_WAIT_ON) |=> active;
  endproperty
  a_expire: assert property (p_expire)
    else $error("channel did not turn on when its delay ran out");

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
    fall |=> state_q == (($past(active) && $past(off_code) != '0)
                         ? seq_pkg::SEQ_WAIT_OFF : seq_pkg::SEQ_OFF);
  endproperty
  a_restart: assert property (p_restart)
    else $error("falling edge did not take over pending sequence");
endmodule
`default_nettype wire

// ### verilog/rail_and_output_sequencing.sv
// Sequencing of linear regulator B and two auxiliary outputs, with config.
//
// Function
// - Regulator B turns off off-code times off-step after enable falls.
// - Regulator B turns on on-code times on-step after enable rises.
// - Aux output A falls its off-delay after enable falls; code resets 0.
// - Aux output A rises its on-delay after enable rises; code resets 10.
// - Aux output B falls its off-delay after enable falls; code resets 3.
// - Aux output B rises its on-delay after enable rises; code resets 2.
// - Startup step is 0.5 ms, or 1 ms when startup range bit is set.
// - Shutdown step is 0.5 ms, or 1 ms when shutdown range bit is set.
// - Aux B is push-pull when drive bit is 0, open-drain when 1.
// - Aux B gating 0: level bit alone; 1: level bit and enable pin.
// - Aux B follows its level bit, subject to gating; level resets 1.
// - Aux A is push-pull when drive bit is 0, open-drain when 1.
// - Aux A gating 0: level bit alone; 1: level bit and enable pin.
// - Aux A follows its level bit, subject to gating; level resets 1.
// - Shared pin is aux output B when function bit 0, clock input when 1.
// - Shared pin pull-down follows its bit in either pin function.
// - Enable pin pull-down follows its bit, which resets to 1.
// - Thermal warning threshold 125 C when bit 0, 137 C when 1.
// - Spread spectrum modulation follows its bit, which resets to 0.
`include "seq_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module rail_and_output_sequencing #(
  parameter int HALF_STEP_CYCLES = `STEP_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Enable pin
  input  wire logic       en_pin,
  // Register port from the serial interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata_q,
  // Sequenced regulator enable
  output var  logic       linear_reg_b_en_q,
  // Auxiliary output A pin
  output var  logic       aux_a_out_q,
  output var  logic       aux_a_oe_n_q,
  // Shared pin, auxiliary output B side
  output var  logic       aux_b_out_q,
  output var  logic       aux_b_oe_n_q,
  // Device-wide settings
  output var  logic       ext_clock_sel_q,
  output var  logic       shared_pin_pulldown_q,
  output var  logic       enable_pin_pulldown_q,
  output var  logic       thermal_warn_high_q,
  output var  logic       spread_spectrum_on_q
);
  localparam int NCH = 3;

  logic [7:0] dly_q [NCH];
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic       en_prev_q;
  logic       en_rise;
  logic       en_fall;
  logic       half_tick;
  logic [NCH-1:0] seq_active;
  logic       aux_a_lvl;
  logic       aux_b_lvl;

  // Register writes. Delay index 0 is regulator B, 1 is A, 2 is B output.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q[0] <= `RST_LRB_DELAY;
      dly_q[1] <= `RST_AUX_A_DELAY;
      dly_q[2] <= `RST_AUX_B_DELAY;
    end else if (reg_wr) begin
      if (reg_addr == `REG_LRB_DELAY) begin
        dly_q[0] <= reg_wdata;
      end else if (reg_addr == `REG_AUX_A_DELAY) begin
        dly_q[1] <= reg_wdata;
      end else if (reg_addr == `REG_AUX_B_DELAY) begin
        dly_q[2] <= reg_wdata;
      end
    end
  end

  // Reserved control bits are read-only zero, so writes to them drop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `RST_AUX_CTRL;
    end else if (reg_wr && reg_addr == `REG_AUX_CTRL) begin
      ctrl_q <= reg_wdata & `CTRL_WR_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `RST_SEQ_CONFIG;
    end else if (reg_wr && reg_addr == `REG_SEQ_CONFIG) begin
      cfg_q <= reg_wdata;
    end
  end

  // Read data is registered; an unmapped address reads as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `REG_LRB_DELAY) begin
        reg_rdata_q <= dly_q[0];
      end else if (reg_addr == `REG_AUX_A_DELAY) begin
        reg_rdata_q <= dly_q[1];
      end else if (reg_addr == `REG_AUX_B_DELAY) begin
        reg_rdata_q <= dly_q[2];
      end else if (reg_addr == `REG_AUX_CTRL) begin
        reg_rdata_q <= ctrl_q;
      end else if (reg_addr == `REG_SEQ_CONFIG) begin
        reg_rdata_q <= cfg_q;
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

  // The pin is taken as synchronous, so one flop suffices for edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_pin;
    end
  end

  assign en_rise = en_pin && !en_prev_q;
  assign en_fall = !en_pin && en_prev_q;

  tick_divider #(
    .HALF_CYCLES (HALF_STEP_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (en_rise || en_fall),
    .tick_q  (half_tick)
  );

  // Codes are sampled at the edge; later writes act on the next edge.
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_chan
      delay_channel #(
        .CODE_W (4),
        .CNT_W  (5)
      ) u_chan (
        .clk      (clk),
        .rst_n    (rst_n),
        .rise     (en_rise),
        .fall     (en_fall),
        .tick     (half_tick),
        .on_code  (dly_q[i][`DLY_ON_MSB:`DLY_ON_LSB]),
        .off_code (dly_q[i][`DLY_OFF_MSB:`DLY_OFF_LSB]),
        .on_long  (cfg_q[`CFG_ON_RANGE]),
        .off_long (cfg_q[`CFG_OFF_RANGE]),
        .active   (seq_active[i])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linear_reg_b_en_q <= 1'b0;
    end else begin
      linear_reg_b_en_q <= seq_active[0];
    end
  end

  // With gating on, the sequenced enable qualifies the level bit.
  assign aux_a_lvl = ctrl_q[`CTRL_AUX_A_LEVEL] &&
                     (!ctrl_q[`CTRL_AUX_A_GATE] || seq_active[1]);
  assign aux_b_lvl = ctrl_q[`CTRL_AUX_B_LEVEL] &&
                     (!ctrl_q[`CTRL_AUX_B_GATE] || seq_active[2]);

  // Open drain releases the pin for high; the external pull-up lifts it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_a_out_q  <= 1'b0;
      aux_a_oe_n_q <= 1'b1;
    end else if (ctrl_q[`CTRL_AUX_A_DRIVE]) begin
      aux_a_out_q  <= 1'b0;
      aux_a_oe_n_q <= aux_a_lvl;
    end else begin
      aux_a_out_q  <= aux_a_lvl;
      aux_a_oe_n_q <= 1'b0;
    end
  end

  // In clock-input function the pin is released whatever the settings.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_b_out_q  <= 1'b0;
      aux_b_oe_n_q <= 1'b1;
    end else if (cfg_q[`CFG_PIN_FUNC]) begin
      aux_b_out_q  <= 1'b0;
      aux_b_oe_n_q <= 1'b1;
    end else if (ctrl_q[`CTRL_AUX_B_DRIVE]) begin
      aux_b_out_q  <= 1'b0;
      aux_b_oe_n_q <= aux_b_lvl;
    end else begin
      aux_b_out_q  <= aux_b_lvl;
      aux_b_oe_n_q <= 1'b0;
    end
  end

  // Analog settings are passed out as registered levels.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clock_sel_q       <= 1'b0;
      shared_pin_pulldown_q <= 1'b0;
      enable_pin_pulldown_q <= 1'b1;
      thermal_warn_high_q   <= 1'b1;
      spread_spectrum_on_q  <= 1'b0;
    end else begin
      ext_clock_sel_q       <= cfg_q[`CFG_PIN_FUNC];
      shared_pin_pulldown_q <= cfg_q[`CFG_SHARED_PD];
      enable_pin_pulldown_q <= cfg_q[`CFG_ENABLE_PD];
      thermal_warn_high_q   <= cfg_q[`CFG_TWARN_LEVEL];
      spread_spectrum_on_q  <= cfg_q[`CFG_SPREAD];
    end
  end

  property p_aux_a_od;
    @(posedge clk) disable iff (!rst_n)
    ctrl_q[`CTRL_AUX_A_DRIVE] |=> !aux_a_out_q;
  endproperty
  a_aux_a_od: assert property (p_aux_a_od)
    else $error("aux A actively driven high in open-drain mode");

  property p_aux_a_plain;
    @(posedge clk) disable iff (!rst_n)
    !ctrl_q[`CTRL_AUX_A_GATE] |=>
      (aux_a_oe_n_q || aux_a_out_q) == $past(ctrl_q[`CTRL_AUX_A_LEVEL]);
  endproperty
  a_aux_a_plain: assert property (p_aux_a_plain)
    else $error("ungated aux A does not follow its level bit");

  property p_aux_b_gated;
    @(posedge clk) disable iff (!rst_n)
    (!cfg_q[`CFG_PIN_FUNC] && ctrl_q[`CTRL_AUX_B_GATE] && !seq_active[2]
     && !ctrl_q[`CTRL_AUX_B_DRIVE]) |=> !aux_b_out_q && !aux_b_oe_n_q;
  endproperty
  a_aux_b_gated: assert property (p_aux_b_gated)
    else $error("gated aux B high while its sequence is off");

  property p_aux_b_level;
    @(posedge clk) disable iff (!rst_n)
    (!cfg_q[`CFG_PIN_FUNC] && !ctrl_q[`CTRL_AUX_B_LEVEL]) |=>
      !aux_b_oe_n_q && !aux_b_out_q;
  endproperty
  a_aux_b_level: assert property (p_aux_b_level)
    else $error("aux B not low with level bit clear");

  property p_clock_fn;
    @(posedge clk) disable iff (!rst_n)
    cfg_q[`CFG_PIN_FUNC] |=> aux_b_oe_n_q && ext_clock_sel_q;
  endproperty
  a_clock_fn: assert property (p_clock_fn)
    else $error("shared pin driven while used as clock input");

  property p_cfg_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `REG_SEQ_CONFIG) |=> ##1
      (spread_spectrum_on_q == $past(reg_wdata[`CFG_SPREAD], 2)) &&
      (thermal_warn_high_q == $past(reg_wdata[`CFG_TWARN_LEVEL], 2));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not reflected two cycles later");

  property p_pulldowns;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `REG_SEQ_CONFIG) |=> ##1
      (shared_pin_pulldown_q == $past(reg_wdata[`CFG_SHARED_PD], 2)) &&
      (enable_pin_pulldown_q == $past(reg_wdata[`CFG_ENABLE_PD], 2));
  endproperty
  a_pulldowns: assert property (p_pulldowns)
    else $error("pull-down controls do not follow config write");

  property p_zero_on;
    @(posedge clk) disable iff (!rst_n)
    (en_rise && dly_q[0][`DLY_ON_MSB:`DLY_ON_LSB] == 4'h0) ##1 !en_fall
      |=> linear_reg_b_en_q;
  endproperty
  a_zero_on: assert property (p_zero_on)
    else $error("regulator B late with zero startup code");

  property p_zero_off;
    @(posedge clk) disable iff (!rst_n)
    (en_fall && dly_q[0][`DLY_OFF_MSB:`DLY_OFF_LSB] == 4'h0) ##1 !en_rise
      |=> !linear_reg_b_en_q;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("regulator B late off with zero shutdown code");

  property p_rd_delay;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `REG_LRB_DELAY) |=>
      reg_rdata_q == $past(dly_q[0]);
  endproperty
  a_rd_delay: assert property (p_rd_delay)
    else $error("regulator B delay register read back wrong");

  property p_rd_unmapped;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_addr < `REG_LRB_DELAY || reg_addr > `REG_SEQ_CONFIG))
      |=> reg_rdata_q == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped address did not read as zero");

  property p_dly_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `REG_AUX_A_DELAY) |=>
      dly_q[1] == $past(reg_wdata);
  endproperty
  a_dly_write: assert property (p_dly_write)
    else $error("aux A delay write not stored");

  property p_ctrl_mask;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `REG_AUX_CTRL) |=>
      ctrl_q == ($past(reg_wdata) & `CTRL_WR_MASK);
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask)
    else $error("control write stored a reserved bit");

  property p_aux_a_gated;
    @(posedge clk) disable iff (!rst_n)
    (ctrl_q[`CTRL_AUX_A_GATE] && !seq_active[1]) |=>
      !aux_a_oe_n_q && !aux_a_out_q;
  endproperty
  a_aux_a_gated: assert property (p_aux_a_gated)
    else $error("gated aux A not low while its sequence is off");

  property p_aux_b_od;
    @(posedge clk) disable iff (!rst_n)
    (!cfg_q[`CFG_PIN_FUNC] && ctrl_q[`CTRL_AUX_B_DRIVE]) |=> !aux_b_out_q;
  endproperty
  a_aux_b_od: assert property (p_aux_b_od)
    else $error("aux B actively driven high in open-drain mode");
endmodule
`default_nettype wire

// ### verilog/seq_consts.svh
// Register map, field positions, reset values and timing for sequencing.
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define REG_LRB_DELAY      8'h0F
`define REG_AUX_A_DELAY    8'h10
`define REG_AUX_B_DELAY    8'h11
`define REG_AUX_CTRL       8'h12
`define REG_SEQ_CONFIG     8'h13

`define RST_LRB_DELAY      8'h26
`define RST_AUX_A_DELAY    8'h0A
`define RST_AUX_B_DELAY    8'h32
`define RST_AUX_CTRL       8'h77
`define RST_SEQ_CONFIG     8'h06

`define DLY_OFF_MSB        7
`define DLY_OFF_LSB        4
`define DLY_ON_MSB         3
`define DLY_ON_LSB         0

`define CTRL_WR_MASK       8'h77
`define CTRL_AUX_B_DRIVE   6
`define CTRL_AUX_B_GATE    5
`define CTRL_AUX_B_LEVEL   4
`define CTRL_AUX_A_DRIVE   2
`define CTRL_AUX_A_GATE    1
`define CTRL_AUX_A_LEVEL   0

`define CFG_ON_RANGE       6
`define CFG_OFF_RANGE      5
`define CFG_PIN_FUNC       4
`define CFG_SHARED_PD      3
`define CFG_ENABLE_PD      2
`define CFG_TWARN_LEVEL    1
`define CFG_SPREAD         0

`define CLK_PERIOD_NS      5
`define STEP_HALF_NS       500000
`define STEP_HALF_CYCLES   (`STEP_HALF_NS / `CLK_PERIOD_NS)

`endif

// ### verilog/seq_pkg.sv
// Types shared by the sequencing modules.
package seq_pkg;
  typedef enum logic [1:0] {
    SEQ_OFF      = 2'h0,
    SEQ_WAIT_ON  = 2'h1,
    SEQ_ON       = 2'h3,
    SEQ_WAIT_OFF = 2'h2
  } seq_state_e;
endpackage

// ### verilog/tick_divider.sv
// Half-step time base that restarts on every enable edge.
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int HALF_CYCLES = 100000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic restart,
  output var  logic tick_q
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // Restarting aligns every delay to the edge, so no step is short.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (restart) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire
